//--- seep_pkg.sv
// constants and types of the two-wire serial memory target
// assumes a 10 MHz pclk and a 32-bit apb register bus
package seep_pkg;

   // clock and programming time
   localparam int unsigned SEEP_PCLK_HZ = 10_000_000;
   localparam int unsigned SEEP_WR_TIME_MS = 5;
   // longest time, rounded down to whole cycles
   localparam int unsigned SEEP_WR_CYCLES = SEEP_PCLK_HZ / 1000 * SEEP_WR_TIME_MS;

   // array geometry
   localparam int unsigned SEEP_ADDR_W = 9;
   localparam int unsigned SEEP_WORDS = 512;
   localparam int unsigned SEEP_PAGE_BYTES = 16;
   localparam logic [7:0] SEEP_MEM_RESET = 8'hff;

   // selection byte layout
   localparam logic [3:0] SEEP_FAMILY = 4'ha;
   localparam int unsigned SEEP_SEL_STRAP_HI = 3;
   localparam int unsigned SEEP_SEL_STRAP_LO = 2;
   localparam int unsigned SEEP_SEL_PAGE = 1;
   localparam int unsigned SEEP_SEL_RW = 0;

   // bit counter values
   localparam logic [3:0] SEEP_BITS_BYTE = 4'h8;
   localparam logic [3:0] SEEP_CNT_RESET = 4'h0;

   // register offsets and reset values
   localparam logic [11:0] SEEP_OFF_CTRL = 12'h000;
   localparam logic [11:0] SEEP_OFF_STATUS = 12'h004;
   localparam int unsigned SEEP_CTRL_EN = 0;
   localparam logic SEEP_CTRL_EN_RESET = 1'b1;

   // protocol states
   typedef enum logic [4:0] {
      SEEP_IDLE  = 5'b00001,
      SEEP_ADDR  = 5'b00010,
      SEEP_WORD  = 5'b00100,
      SEEP_WRITE = 5'b01000,
      SEEP_READ  = 5'b10000
   } seep_state_e;

   // status word as software sees it
   typedef struct packed {
      logic [6:0] zero_hi;
      logic [8:0] addr;
      logic [13:0] zero_lo;
      logic active;
      logic busy;
   } seep_status_s;

endpackage

//--- seep_target.sv
// two-wire serial memory target with a 512 x 8 array and apb control
// assumes scl, sda and straps come from pins outside the pclk domain
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - incoming data bits are taken on rising edges of the serial clock.
// - every outgoing bit, acknowledges included, changes after a falling serial clock edge.
// - the data line is only pulled low or released, never driven high.
// - the device answers only when the two strap inputs match the selection byte.
// - the lowest address pin is read by nothing.
// - with protect high, bytes whose word address msb is set are never programmed.
// - with protect low, the whole array can be read and written.
// - storage is 32 pages of 16 bytes, page picked by the upper address bits.
// - a byte is selected by a full 9-bit word address.
// - a short page write programs just the bytes received.
// - programming runs on its own timer after the stop, within the write time.
// - sda falling with scl high is a start, sda rising with scl high is a stop.
// - each received byte, except a refused selection byte, is acknowledged by pulling sda low in the ninth clock.
// - the selection byte holds family prefix, straps, address msb and read flag.
// - during a page write only the low four address bits advance, wrapping in the page.
module seep_target #(
   parameter int unsigned WR_CYCLES = seep_pkg::SEEP_WR_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // straps and protect
   input wire logic chip_select_strap_high,
   input wire logic chip_select_strap_low,
   input wire logic unused_address_pin,
   input wire logic wp_i
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic scl_prev_q;
   logic sda_prev_q;

   // two stages for every pin input, unused pin left out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 5'h1f;
         sync2_q <= 5'h1f;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         sync1_q <= {scl_i, sda_i, chip_select_strap_high, chip_select_strap_low, wp_i};
         sync2_q <= sync1_q;
         scl_prev_q <= sync2_q[4];
         sda_prev_q <= sync2_q[3];
      end
   end

   wire scl_s = sync2_q[4];
   wire sda_s = sync2_q[3];
   wire strap_hi_s = sync2_q[2];
   wire strap_lo_s = sync2_q[1];
   wire wp_s = sync2_q[0];

   // edge and condition decode
   wire scl_rise = scl_s && !scl_prev_q;
   wire scl_fall = !scl_s && scl_prev_q;
   wire bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   wire bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // protocol state

   seep_pkg::seep_state_e st_q;
   logic [3:0] cnt_q;
   logic [7:0] rx_q;
   logic [7:0] rbyte_q;
   logic [8:0] addr_q;
   logic ack_q;
   logic rw_q;
   logic oe_q;
   logic busy_q;
   logic en_q;
   logic [7:0] mem_q [seep_pkg::SEEP_WORDS];
   logic [7:0] pbuf_q [seep_pkg::SEEP_PAGE_BYTES];
   logic [15:0] mask_q;
   logic [4:0] page_q;

   // byte decode
   wire rx_st = (st_q == seep_pkg::SEEP_ADDR) || (st_q == seep_pkg::SEEP_WORD)
      || (st_q == seep_pkg::SEEP_WRITE);
   wire byte_done = scl_fall && rx_st && (cnt_q == seep_pkg::SEEP_BITS_BYTE) && !ack_q;
   wire ack_end = scl_fall && rx_st && ack_q;
   wire dev_match = (rx_q[7:4] == seep_pkg::SEEP_FAMILY)
      && (rx_q[seep_pkg::SEEP_SEL_STRAP_HI] == strap_hi_s)
      && (rx_q[seep_pkg::SEEP_SEL_STRAP_LO] == strap_lo_s);
   wire sel_ok = dev_match && !busy_q && en_q;
   wire addr_ev = byte_done && (st_q == seep_pkg::SEEP_ADDR);
   wire word_ev = byte_done && (st_q == seep_pkg::SEEP_WORD);
   wire data_ev = byte_done && (st_q == seep_pkg::SEEP_WRITE);
   wire [8:0] sel_addr = {rx_q[seep_pkg::SEEP_SEL_PAGE], addr_q[7:0]};
   wire [8:0] rd_next = addr_q + 9'h001;
   wire [8:0] wr_next = {addr_q[8:4], addr_q[3:0] + 4'h1};
   wire prot_hit = wp_s && addr_q[8];
   wire rd_last = scl_rise && (st_q == seep_pkg::SEEP_READ)
      && (cnt_q == seep_pkg::SEEP_BITS_BYTE);
   wire [3:0] rd_bit = 4'h7 - cnt_q[3:0];
   wire prog_go = bus_stop && (st_q == seep_pkg::SEEP_WRITE) && (|mask_q);
   logic [31:0] tmr_q;
   wire prog_done = busy_q && (tmr_q == 32'h0);

   // serial engine: shift on rise, drive on fall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= seep_pkg::SEEP_IDLE;
         cnt_q <= seep_pkg::SEEP_CNT_RESET;
         rx_q <= 8'h00;
         rbyte_q <= 8'h00;
         addr_q <= 9'h000;
         ack_q <= 1'b0;
         rw_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (bus_start) begin
         st_q <= seep_pkg::SEEP_ADDR;
         cnt_q <= seep_pkg::SEEP_CNT_RESET;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (bus_stop) begin
         st_q <= seep_pkg::SEEP_IDLE;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (scl_rise) begin
         if (rx_st && cnt_q != seep_pkg::SEEP_BITS_BYTE) begin
            rx_q <= {rx_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
         end else if (st_q == seep_pkg::SEEP_READ) begin
            if (cnt_q != seep_pkg::SEEP_BITS_BYTE) begin
               cnt_q <= cnt_q + 4'h1;
            end else begin
               // ack slot of the controller: advance across the whole array
               addr_q <= rd_next;
               rbyte_q <= mem_q[rd_next];
               cnt_q <= seep_pkg::SEEP_CNT_RESET;
               if (sda_s) begin
                  st_q <= seep_pkg::SEEP_IDLE;
               end
            end
         end
      end else if (scl_fall) begin
         if (byte_done) begin
            if (st_q == seep_pkg::SEEP_ADDR && !sel_ok) begin
               st_q <= seep_pkg::SEEP_IDLE;
            end else begin
               oe_q <= 1'b1;
               ack_q <= 1'b1;
            end
            if (addr_ev && sel_ok) begin // foreign selection leaves address alone
               addr_q[8] <= rx_q[seep_pkg::SEEP_SEL_PAGE];
               rw_q <= rx_q[seep_pkg::SEEP_SEL_RW];
               rbyte_q <= mem_q[sel_addr];
            end
            if (word_ev) begin
               addr_q[7:0] <= rx_q;
            end
            if (data_ev) begin
               addr_q <= wr_next;
            end
         end else if (ack_end) begin
            ack_q <= 1'b0;
            cnt_q <= seep_pkg::SEEP_CNT_RESET;
            if (st_q == seep_pkg::SEEP_ADDR && rw_q) begin
               st_q <= seep_pkg::SEEP_READ;
               oe_q <= !rbyte_q[7];
            end else begin
               oe_q <= 1'b0;
               if (st_q == seep_pkg::SEEP_ADDR) begin
                  st_q <= seep_pkg::SEEP_WORD;
               end else begin
                  st_q <= seep_pkg::SEEP_WRITE;
               end
            end
         end else if (st_q == seep_pkg::SEEP_READ) begin
            if (cnt_q != seep_pkg::SEEP_BITS_BYTE) begin
               oe_q <= !rbyte_q[rd_bit[2:0]];
            end else begin
               oe_q <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page buffer

   // collect data bytes of one page, protected ones dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 16'h0000;
         page_q <= 5'h00;
         for (int i = 0; i < seep_pkg::SEEP_PAGE_BYTES; i++) begin
            pbuf_q[i] <= 8'h00;
         end
      end else if (word_ev) begin
         mask_q <= 16'h0000;
         page_q <= {addr_q[8], rx_q[7:4]};
      end else if (data_ev && !prot_hit) begin
         pbuf_q[addr_q[3:0]] <= rx_q;
         mask_q[addr_q[3:0]] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // self-timed programming

   // timer starts at the stop, busy blocks selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         tmr_q <= 32'h0;
      end else if (prog_go && !busy_q) begin
         busy_q <= 1'b1;
         tmr_q <= WR_CYCLES - 32'h1;
      end else if (busy_q) begin
         if (prog_done) begin
            busy_q <= 1'b0;
         end else begin
            tmr_q <= tmr_q - 32'h1;
         end
      end
   end

   // array update at the end of the timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < seep_pkg::SEEP_WORDS; i++) begin
            mem_q[i] <= seep_pkg::SEEP_MEM_RESET;
         end
      end else if (prog_done) begin
         for (int i = 0; i < seep_pkg::SEEP_PAGE_BYTES; i++) begin
            if (mask_q[i]) begin
               mem_q[{page_q, 4'(i)}] <= pbuf_q[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave

   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   seep_pkg::seep_status_s status;

   // status word assembly
   assign status.zero_hi = 7'h00;
   assign status.addr = addr_q;
   assign status.zero_lo = 14'h0000;
   assign status.active = (st_q != seep_pkg::SEEP_IDLE);
   assign status.busy = busy_q;

   // address decode
   wire apb_setup = psel && !penable;
   wire apb_done = psel && penable && pready_q;
   wire hit_ctrl = (paddr == seep_pkg::SEEP_OFF_CTRL);
   wire hit_status = (paddr == seep_pkg::SEEP_OFF_STATUS);
   wire [31:0] rd_mux = hit_ctrl ? {31'h0, en_q} : (hit_status ? status : 32'h0);

   // answer in the access cycle, write lands at its end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         en_q <= seep_pkg::SEEP_CTRL_EN_RESET;
      end else begin
         pready_q <= apb_setup;
         if (apb_setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_mux;
            pslverr_q <= !(hit_ctrl || hit_status) || (pwrite && hit_status);
         end
         if (apb_done && pwrite && hit_ctrl) begin
            en_q <= pwdata[seep_pkg::SEEP_CTRL_EN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sda_o = 1'b0; // open drain: only ever low
   assign sda_oe = oe_q;

endmodule

//--- seep_chk.sv
// assertions on the ports of the two-wire memory target
// assumes pclk drives every sampling and presetn resets all of it
`timescale 1ns/1ps
module seep_chk #(
   parameter int unsigned WR_CYCLES = seep_pkg::SEEP_WR_CYCLES
) (
   // clock, reset and apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial pins and straps
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic chip_select_strap_high,
   input wire logic chip_select_strap_low,
   input wire logic unused_address_pin,
   input wire logic wp_i
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // decode of the two mapped words
   wire logic mapped;
   wire logic st_wr;
   assign mapped = (paddr == 12'h000) || (paddr == 12'h004);
   assign st_wr = pwrite && (paddr == 12'h004);
   ////////////////////////////////////////////////////////////////////////////////
   od_low_a: assert property (sda_o == 1'b0) else $error("sda driven high");
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("sda moved while scl high");
   oe_hold_a: assert property ($changed(sda_oe) |=> $stable(sda_oe)[*4])
      else $error("sda level too short");
   apb_ready_a: assert property (psel && !penable |=> pready && penable)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   unmapped_a: assert property (pready && !mapped |-> pslverr) else $error("no error");
   ro_status_a: assert property (pready && st_wr |-> pslverr) else $error("status written");
   good_ok_a: assert property (pready && mapped && !st_wr |-> !pslverr)
      else $error("spurious error");
   wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data on write");
   // main scenarios reached
   cover property ($rose(sda_oe));
   cover property (pready && pslverr);
   cover property (pready && !pwrite && prdata[0]);
endmodule
bind seep_target seep_chk #(.WR_CYCLES(WR_CYCLES)) chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_strap_high(chip_select_strap_high),
   .chip_select_strap_low(chip_select_strap_low),
   .unused_address_pin(unused_address_pin), .wp_i(wp_i));

//--- seep_ctl_model.sv
// behavioural two-wire bus controller, 800 ns serial clock
// assumes an open-drain sda wire with pull-up resolved outside
`timescale 1ns/1ps
module seep_ctl_model (
   // serial pins
   output logic scl,
   output logic sda_oe,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // one clock: data moves only while scl low, read at mid high
   task automatic clk_bit(input logic b, output logic s);
      #330 sda_oe = !b;
      #70 scl = 1'b1;
      #200 s = sda;
      #200 scl = 1'b0;
   endtask
   // start or repeated start, offset to stay off pclk edges
   task automatic start;
      #343 sda_oe = 1'b0;
      #70 scl = 1'b1;
      #400 sda_oe = 1'b1;
      #400 scl = 1'b0;
   endtask
   task automatic stop;
      #330 sda_oe = 1'b1;
      #70 scl = 1'b1;
      #400 sda_oe = 1'b0;
      #400;
   endtask
   // byte out msb first, ninth clock returns the ack level
   task automatic wr(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) clk_bit(b[i], ack);
      clk_bit(1'b1, ack);
   endtask
   task automatic rd(input logic nak, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         b[i] = s;
      end
      clk_bit(nak, s);
   endtask
endmodule

//--- tb_serial_eeprom_2wire_target.sv
// self-checking bench of the two-wire memory target
// assumes the controller model and checker files compile first
`timescale 1ns/1ps
module tb_serial_eeprom_2wire_target;
   typedef struct {logic [8:0] a; logic [7:0] d; logic wp; logic [7:0] e;} seep_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sda_o, sda_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic scl, m_oe, s_hi, s_lo, a0, wp, e, k;
   wire logic sda;
   int n_errors = 0;
   int checks_done = 0;
   seep_row_s rows [5] = '{'{9'h005, 8'h3c, 1'b0, 8'h3c}, '{9'h105, 8'h5a, 1'b0, 8'h5a},
      '{9'h005, 8'h11, 1'b1, 8'h11}, '{9'h105, 8'h77, 1'b1, 8'h5a},
      '{9'h1ff, 8'ha5, 1'b0, 8'ha5}};
   // open-drain wire with pull-up
   assign sda = !((sda_oe && !sda_o) || m_oe);
   seep_target #(.WR_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .chip_select_strap_high(s_hi), .chip_select_strap_low(s_lo),
      .unused_address_pin(a0), .wp_i(wp));
   seep_ctl_model m (.scl(scl), .sda_oe(m_oe), .sda(sda));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = !pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // apb transfer; pready sampled at the rising edge, request released right after it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic seln(input logic [7:0] s);
      m.start();
      m.wr(s, k);
   endtask
   task automatic put(input logic [8:0] a, input logic [7:0] q[$]);
      seln({6'h2a, a[8], 1'b0});
      chk("sel ack", k, 1'b0);
      m.wr(a[7:0], k);
      chk("word ack", k, 1'b0);
      foreach (q[i]) begin
         m.wr(q[i], k);
         chk("data ack", k, 1'b0);
      end
      m.stop();
   endtask
   task automatic get(input logic [8:0] a, input logic [7:0] q[$]);
      logic [7:0] b;
      seln({6'h2a, a[8], 1'b0});
      m.wr(a[7:0], k);
      seln({6'h2a, a[8], 1'b1});
      chk("read sel ack", k, 1'b0);
      foreach (q[i]) begin
         m.rd(i == q.size() - 1, b);
         chk("read data", b, q[i]);
      end
      m.stop();
   endtask
   // busy checked against the expected level after a stop, then gone within a bounded poll
   task automatic settle(input logic busy);
      int n;
      n = 0;
      repeat (8) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      chk("busy", r[0], busy);
      while (r[0] !== 1'b0 && n < 40) begin
         apb(1'b0, 12'h004, 32'h0);
         n++;
      end
      chk("idle", r[0], 1'b0);
   endtask
   task automatic rst;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl reset", r, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      s_hi = 1'b1;
      s_lo = 1'b0;
      a0 = 1'b0;
      wp = 1'b0;
      presetn = 1'b0;
      rst();
      foreach (rows[i]) begin
         wp <= rows[i].wp;
         put(rows[i].a, '{rows[i].d});
         settle(!(rows[i].wp && rows[i].a[8]));
         get(rows[i].a, '{rows[i].e});
      end
      put(9'h0fe, '{8'h01, 8'h02, 8'h03});
      settle(1'b1);
      get(9'h0fe, '{8'h01, 8'h02, 8'hff});
      get(9'h0f0, '{8'h03, 8'hff});
      apb(1'b0, 12'h004, 32'h0);
      chk("addr", r[24:16], 9'h0f2);
      seln(8'ha6);
      chk("strap mismatch", k, 1'b1);
      m.stop();
      apb(1'b0, 12'h004, 32'h0);
      chk("addr kept", r[24:16], 9'h0f2);
      a0 <= 1'b1;
      seln(8'ha8);
      chk("pin ignored", k, 1'b0);
      m.stop();
      apb(1'b1, 12'h000, 32'h0);
      seln(8'ha8);
      chk("disabled", k, 1'b1);
      m.stop();
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h004, 32'hffff_ffff);
      chk("status ro", e, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped", e, 1'b1);
      rst();
      get(9'h005, '{8'hff});
      close_out();
   end
   // hang guard
   initial begin
      #3_000_000;
      n_errors++;
      close_out();
   end
endmodule
